/* design/adc_ctrl_pkg.sv */
// Constants, states and carriers shared by the converter control block
package adc_ctrl_pkg;

    // ************************************
    // Sizes and counts
    // ************************************
    localparam int RESULT_WIDTH_DEF = 14;
    localparam int SAMPLE_WIDTH_DEF = 16;
    localparam logic [4:0] ACQ_START_EDGE = 5'h10;
    localparam logic [2:0] NAP_PULSES = 3'h2;
    localparam logic [2:0] SLEEP_PULSES = 3'h4;

    // ************************************
    // Types
    // ************************************
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_CONVERT = 3'h1,
        ST_ACQUIRE = 3'h3,
        ST_NAP = 3'h2,
        ST_SLEEP = 3'h6
    } convert_strobe_state_type;

    typedef struct packed
    {
        logic acquiring;
        logic napping;
        logic sleeping;
        logic late_start;
    } status_type;

endpackage

/* design/sample_quantiser.sv */
// Saturating two's complement quantiser for the held differential sample
`timescale 1ns/1ns
module sample_quantiser #(
    parameter int SAMPLE_WIDTH = 16,
    parameter int RESULT_WIDTH = 14
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Held sample
    input wire logic signed [SAMPLE_WIDTH-1:0] pos,
    input wire logic signed [SAMPLE_WIDTH-1:0] neg,
    // Result word
    output logic [RESULT_WIDTH-1:0] result
);
    import adc_ctrl_pkg::*;

    localparam logic signed [SAMPLE_WIDTH:0] MAX_CODE =
        {{(SAMPLE_WIDTH+2-RESULT_WIDTH){1'h0}}, {(RESULT_WIDTH-1){1'h1}}};
    localparam logic signed [SAMPLE_WIDTH:0] MIN_CODE =
        {{(SAMPLE_WIDTH+2-RESULT_WIDTH){1'h1}}, {(RESULT_WIDTH-1){1'h0}}};

    logic signed [SAMPLE_WIDTH:0] diff;
    logic [RESULT_WIDTH-1:0] next_result;

    // ************************************
    // Difference, clamp and register
    // ************************************
    always_comb
    begin
        diff = {pos[SAMPLE_WIDTH-1], pos} - {neg[SAMPLE_WIDTH-1], neg};
        if (diff > MAX_CODE)
            next_result = MAX_CODE[RESULT_WIDTH-1:0];
        else if (diff < MIN_CODE)
            next_result = MIN_CODE[RESULT_WIDTH-1:0];
        else
            next_result = diff[RESULT_WIDTH-1:0];
    end

    // Result register
    always_ff @(posedge clk)
    begin
        if (rst)
            result <= '0;
        else
            result <= next_result;
    end

    a_clamp_high: assert property (@(posedge clk) disable iff (rst)
        diff > MAX_CODE |=> result == {1'h0, {(RESULT_WIDTH-1){1'h1}}})
        else $error("Over-range not clamped to zero then ones");
    a_clamp_low: assert property (@(posedge clk) disable iff (rst)
        diff < MIN_CODE |=> result == {1'h1, {(RESULT_WIDTH-1){1'h0}}})
        else $error("Under-range not clamped to one then zeros");
    a_twos_complement: assert property (@(posedge clk) disable iff (rst)
        (diff <= MAX_CODE && diff >= MIN_CODE)
        |=> $signed(result) == $past(diff))
        else $error("In-range result is not the two's complement difference");

endmodule

/* design/serial_adc_conversion_ctrl.sv */
// Convert strobe, serial clock sequencing, shutdown and serial result output
`timescale 1ns/1ns
module serial_adc_conversion_ctrl #(
    parameter int RESULT_WIDTH = adc_ctrl_pkg::RESULT_WIDTH_DEF,
    parameter int SAMPLE_WIDTH = adc_ctrl_pkg::SAMPLE_WIDTH_DEF
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Host pins
    input wire logic SERIAL_CLOCK,
    input wire logic CONVERT_STROBE,
    // Digitised analog inputs
    input wire logic signed [SAMPLE_WIDTH-1:0] POSITIVE_ANALOG_INPUT,
    input wire logic signed [SAMPLE_WIDTH-1:0] NEGATIVE_ANALOG_INPUT,
    // Three-state serial result
    output logic SERIAL_RESULT_OUT,
    output logic SERIAL_RESULT_OE_N,
    // State report
    output adc_ctrl_pkg::status_type STATUS
);
    import adc_ctrl_pkg::*;

    localparam int CW = $clog2(RESULT_WIDTH + 1);
    localparam logic [CW-1:0] WORD_BITS = CW'(RESULT_WIDTH);

    // ************************************
    // Pin synchronisers
    // ************************************
    logic [1:0] sck_sync;
    logic [1:0] convert_strobe_sync;
    logic sck_prev;
    logic convert_strobe_prev;
    logic signed [SAMPLE_WIDTH-1:0] ain_p_sync [2];
    logic signed [SAMPLE_WIDTH-1:0] ain_n_sync [2];
    logic sck_rise;
    logic sck_edge;
    logic convert_strobe_rise;

    // Two flops per pin, then an edge history flop on the clock and strobe pins only
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            sck_sync <= 2'h0;
            convert_strobe_sync <= 2'h0;
            sck_prev <= 1'h0;
            convert_strobe_prev <= 1'h0;
            ain_p_sync[0] <= '0;
            ain_p_sync[1] <= '0;
            ain_n_sync[0] <= '0;
            ain_n_sync[1] <= '0;
        end
        else
        begin
            sck_sync <= {sck_sync[0], SERIAL_CLOCK};
            convert_strobe_sync <= {convert_strobe_sync[0], CONVERT_STROBE};
            sck_prev <= sck_sync[1];
            convert_strobe_prev <= convert_strobe_sync[1];
            ain_p_sync[0] <= POSITIVE_ANALOG_INPUT;
            ain_p_sync[1] <= ain_p_sync[0];
            ain_n_sync[0] <= NEGATIVE_ANALOG_INPUT;
            ain_n_sync[1] <= ain_n_sync[0];
        end
    end

    // Edge detection on the second stage only
    assign sck_rise = sck_sync[1] & ~sck_prev;
    assign sck_edge = sck_sync[1] ^ sck_prev;
    assign convert_strobe_rise = convert_strobe_sync[1] & ~convert_strobe_prev;

    // ************************************
    // Sample hold and quantiser
    // ************************************
    logic signed [SAMPLE_WIDTH-1:0] hold_p;
    logic signed [SAMPLE_WIDTH-1:0] hold_n;
    logic [RESULT_WIDTH-1:0] quant_result;

    sample_quantiser #(
        .SAMPLE_WIDTH(SAMPLE_WIDTH),
        .RESULT_WIDTH(RESULT_WIDTH)
    ) quantiser (
        .clk(REF_CLK),
        .rst(RST),
        .pos(hold_p),
        .neg(hold_n),
        .result(quant_result)
    );

    // ************************************
    // Conversion sequencer and shifter
    // ************************************
    convert_strobe_state_type state;
    convert_strobe_state_type next_state;
    logic [4:0] sck_count;
    logic [4:0] next_sck_count;
    logic [2:0] pulses;
    logic [2:0] next_pulses;
    logic [RESULT_WIDTH-1:0] shift;
    logic [RESULT_WIDTH-1:0] next_shift;
    logic [CW-1:0] bits_left;
    logic [CW-1:0] next_bits_left;
    logic drive;
    logic next_drive;
    logic late;
    logic next_late;
    logic signed [SAMPLE_WIDTH-1:0] next_hold_p;
    logic signed [SAMPLE_WIDTH-1:0] next_hold_n;
    logic start_convert_strobe;
    status_type next_status;

    // Next values for the whole sequence
    always_comb
    begin
        next_state = state;
        next_sck_count = sck_count;
        next_pulses = pulses;
        next_shift = shift;
        next_bits_left = bits_left;
        next_drive = drive;
        next_late = late;
        next_hold_p = hold_p;
        next_hold_n = hold_n;
        start_convert_strobe = 1'h0;
        if (convert_strobe_rise)
        begin
            // Strobe pulses counted while the clock stands still
            if (sck_edge)
                next_pulses = 3'h1;
            else if (pulses < SLEEP_PULSES)
                next_pulses = pulses + 3'h1;
            if (next_pulses >= SLEEP_PULSES)
            begin
                next_state = ST_SLEEP;
                next_drive = 1'h0;
                next_late = 1'h0;
            end
            else if (next_pulses >= NAP_PULSES)
            begin
                next_state = ST_NAP;
                next_drive = 1'h0;
                next_late = 1'h0;
            end
            else
            begin
                start_convert_strobe = 1'h1;
                next_state = ST_CONVERT;
                next_hold_p = ain_p_sync[1];
                next_hold_n = ain_n_sync[1];
                next_sck_count = 5'h00;
                next_shift = quant_result;
                next_bits_left = WORD_BITS;
                next_late = sck_rise;
                next_drive = ~sck_rise;
            end
        end
        else if (sck_rise)
        begin
            next_pulses = 3'h0;
            case (state)
                ST_NAP, ST_SLEEP:
                    next_state = ST_IDLE;
                ST_CONVERT:
                begin
                    next_sck_count = sck_count + 5'h01;
                    if (next_sck_count == ACQ_START_EDGE)
                        next_state = ST_ACQUIRE;
                end
                default:
                    next_state = state;
            endcase
            if (late)
            begin
                next_late = 1'h0;
                next_drive = 1'h1;
            end
            else if (drive)
            begin
                next_shift = {shift[RESULT_WIDTH-2:0], 1'h0};
                next_bits_left = bits_left - {{(CW-1){1'h0}}, 1'h1};
                if (bits_left == {{(CW-1){1'h0}}, 1'h1})
                    next_drive = 1'h0;
            end
        end
        else if (sck_edge)
        begin
            next_pulses = 3'h0;
        end
        next_status.acquiring = (next_state == ST_ACQUIRE);
        next_status.napping = (next_state == ST_NAP);
        next_status.sleeping = (next_state == ST_SLEEP);
        next_status.late_start = next_late;
    end

    // Sequence registers and output flops
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            state <= ST_IDLE;
            sck_count <= 5'h00;
            pulses <= 3'h0;
            shift <= '0;
            bits_left <= '0;
            drive <= 1'h0;
            late <= 1'h0;
            hold_p <= '0;
            hold_n <= '0;
            SERIAL_RESULT_OUT <= 1'h0;
            SERIAL_RESULT_OE_N <= 1'h1;
            STATUS <= '0;
        end
        else
        begin
            state <= next_state;
            sck_count <= next_sck_count;
            pulses <= next_pulses;
            shift <= next_shift;
            bits_left <= next_bits_left;
            drive <= next_drive;
            late <= next_late;
            hold_p <= next_hold_p;
            hold_n <= next_hold_n;
            SERIAL_RESULT_OUT <= next_drive & next_shift[RESULT_WIDTH-1];
            SERIAL_RESULT_OE_N <= ~next_drive;
            STATUS <= next_status;
        end
    end

    // ************************************
    // Checks
    // ************************************
    a_strobe_holds_input: assert property (@(posedge REF_CLK) disable iff (RST)
        start_convert_strobe |=> hold_p == $past(ain_p_sync[1]) && state == ST_CONVERT)
        else $error("Strobe did not capture the input");
    a_clock_steps_count: assert property (@(posedge REF_CLK) disable iff (RST)
        state == ST_CONVERT && sck_rise && !convert_strobe_rise
        |=> sck_count == $past(sck_count) + 5'h01)
        else $error("Clock rise did not step the conversion");
    a_late_strobe_delay: assert property (@(posedge REF_CLK) disable iff (RST)
        start_convert_strobe && sck_rise |=> SERIAL_RESULT_OE_N && STATUS.late_start)
        else $error("Late strobe did not delay the data");
    a_prompt_msb_out: assert property (@(posedge REF_CLK) disable iff (RST)
        start_convert_strobe && !sck_rise
        |=> !SERIAL_RESULT_OE_N && SERIAL_RESULT_OUT == $past(quant_result[RESULT_WIDTH-1]))
        else $error("Previous result MSB not presented after strobe");
    a_acquire_at_edge: assert property (@(posedge REF_CLK) disable iff (RST)
        state == ST_CONVERT && sck_rise && !convert_strobe_rise && sck_count == ACQ_START_EDGE - 5'h01
        |=> state == ST_ACQUIRE && STATUS.acquiring)
        else $error("Acquisition did not start at the set clock edge");
    a_nap_entry: assert property (@(posedge REF_CLK) disable iff (RST)
        convert_strobe_rise && !sck_edge && pulses == NAP_PULSES - 3'h1
        |=> STATUS.napping && SERIAL_RESULT_OE_N)
        else $error("Two static-clock strobes did not enter nap");
    a_sleep_entry: assert property (@(posedge REF_CLK) disable iff (RST)
        convert_strobe_rise && !sck_edge && pulses == SLEEP_PULSES - 3'h1 |=> STATUS.sleeping)
        else $error("Four static-clock strobes did not enter sleep");
    a_clock_wakes: assert property (@(posedge REF_CLK) disable iff (RST)
        (state == ST_SLEEP || state == ST_NAP) && sck_rise && !convert_strobe_rise
        |=> state == ST_IDLE && !STATUS.sleeping && !STATUS.napping)
        else $error("Clock pulse did not wake the device");
    a_window_closes: assert property (@(posedge REF_CLK) disable iff (RST)
        drive && !late && bits_left == {{(CW-1){1'h0}}, 1'h1} && sck_rise && !convert_strobe_rise
        |=> SERIAL_RESULT_OE_N)
        else $error("Output still driven after the last result bit");

endmodule

/* verif/adc_host_model.sv */
// Host model: makes the serial clock and convert strobe, latches result bits
`timescale 1ns/1ns
module adc_host_model (
    // Clock
    input wire logic ref_clk,
    // Result pins of both variants
    input wire logic wide_out,
    input wire logic wide_oe_n,
    input wire logic narrow_out,
    input wire logic narrow_oe_n,
    // Host pins
    output logic sclk,
    output logic strobe
);
    logic [15:0] wide_word;
    logic [15:0] narrow_word;
    int wide_bits;
    int narrow_bits;
    int first_bit;

    // Pins idle low; the clock stands still between frames
    initial
    begin
        sclk = 1'h0;
        strobe = 1'h0;
    end

    // Each pin level stands 400 ns, so an 800 ns clock period, inside its limits
    task automatic hold();
        repeat (4) @(negedge ref_clk);
    endtask

    // Park the clock at a static level
    task automatic set_clock(input logic lvl);
        sclk = lvl;
        hold();
    endtask

    // Strobe pulses while the clock stays static
    task automatic pulses(input int n);
        repeat (n)
        begin
            strobe = 1'h1;
            hold();
            strobe = 1'h0;
            hold();
        end
    endtask

    // Strobe, then sixteen clock rises; late raises clock and strobe together
    task automatic frame(input bit late);
        wide_word = '0;
        narrow_word = '0;
        wide_bits = 0;
        narrow_bits = 0;
        first_bit = 0;
        strobe = 1'h1;
        sclk = late;
        hold();
        strobe = 1'h0;
        sclk = 1'h0;
        hold();
        for (int k = late ? 2 : 1; k <= 16; k++)
        begin
            // Bits are taken as the clock rises, only while driven
            if (wide_oe_n === 1'h0)
            begin
                wide_word = {wide_word[14:0], wide_out};
                wide_bits++;
                first_bit = (first_bit == 0) ? k : first_bit;
            end
            if (narrow_oe_n === 1'h0)
            begin
                narrow_word = {narrow_word[14:0], narrow_out};
                narrow_bits++;
            end
            sclk = 1'h1;
            hold();
            sclk = 1'h0;
            hold();
        end
        // Gap after the 16th rise leaves acquisition time before the next strobe
        hold();
    endtask
endmodule

/* verif/serial_adc_conversion_ctrl_test.sv */
// Testbench: both result widths side by side, driven by one host model
`timescale 1ns/1ns
module serial_adc_conversion_ctrl_test;
    import adc_ctrl_pkg::*;

    localparam int NARROW_WIDTH = 12;
    logic ref_clk;
    logic rst;
    logic sclk;
    logic strobe;
    logic signed [15:0] pos;
    logic signed [15:0] neg;
    logic out_w;
    logic oe_n_w;
    logic out_n;
    logic oe_n_n;
    status_type status_w;
    status_type status_n;
    int err_total = 0;
    int checks_done = 0;
    int prev_d = 0;

    // ****************************************
    // Clock, parts under test and host
    // ****************************************
    always #50 ref_clk = ~ref_clk;

    serial_adc_conversion_ctrl #(.RESULT_WIDTH(RESULT_WIDTH_DEF))
        serial_adc_conversion_ctrl_i (
        .REF_CLK(ref_clk), .RST(rst), .SERIAL_CLOCK(sclk), .CONVERT_STROBE(strobe),
        .POSITIVE_ANALOG_INPUT(pos), .NEGATIVE_ANALOG_INPUT(neg),
        .SERIAL_RESULT_OUT(out_w), .SERIAL_RESULT_OE_N(oe_n_w), .STATUS(status_w)
    );

    serial_adc_conversion_ctrl #(.RESULT_WIDTH(NARROW_WIDTH))
        serial_adc_conversion_ctrl_narrow_i (
        .REF_CLK(ref_clk), .RST(rst), .SERIAL_CLOCK(sclk), .CONVERT_STROBE(strobe),
        .POSITIVE_ANALOG_INPUT(pos), .NEGATIVE_ANALOG_INPUT(neg),
        .SERIAL_RESULT_OUT(out_n), .SERIAL_RESULT_OE_N(oe_n_n), .STATUS(status_n)
    );

    adc_host_model adc_host_model_i (
        .ref_clk(ref_clk), .wide_out(out_w), .wide_oe_n(oe_n_w), .narrow_out(out_n),
        .narrow_oe_n(oe_n_n), .sclk(sclk), .strobe(strobe)
    );

    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Saturated two's complement code of a difference, w bits wide
    function automatic logic [15:0] expect_code(input int d, input int w);
        int lim;
        lim = 2 ** (w - 1);
        d = (d > lim - 1) ? lim - 1 : d;
        d = (d < -lim) ? -lim : d;
        return 16'(d) & 16'((1 << w) - 1);
    endfunction

    // One frame on both widths, judged against the previous sample
    task automatic frame_check(input bit late);
        adc_host_model_i.frame(late);
        check_val(adc_host_model_i.wide_word, expect_code(prev_d, RESULT_WIDTH_DEF), "wide");
        check_val(adc_host_model_i.narrow_word, expect_code(prev_d, NARROW_WIDTH), "narrow");
        check_val(16'(adc_host_model_i.wide_bits), 16'h000e, "wide bits");
        check_val(16'(adc_host_model_i.narrow_bits), 16'h000c, "narrow bits");
        check_val(16'(adc_host_model_i.first_bit == 1), 16'(!late), "first bit");
        check_val(16'({oe_n_w, oe_n_n}), 16'h0003, "float after frame");
        if (!late)
            check_val(16'(status_w.acquiring), 16'h0001, "acquiring");
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        check_val(16'({out_w, oe_n_w, status_w}), 16'h0010, "reset wide");
        check_val(16'({out_n, oe_n_n, status_n}), 16'h0010, "reset narrow");
    endtask

    // Signed values, both saturations and both width limits, one frame late
    task automatic t_pipeline();
        int p[7] = '{100, 1000, 9000, -9000, 8191, -8192, 2047};
        int q[7] = '{300, 3000, 0, 0, 0, 0, 0};
        for (int i = 0; i <= 7; i++)
        begin
            if (i < 7)
            begin
                pos = 16'(p[i]);
                neg = 16'(q[i]);
            end
            frame_check(1'h0);
            prev_d = p[(i < 7) ? i : 6] - q[(i < 7) ? i : 6];
        end
    endtask

    // Strobe and clock rise seen together delay the stream
    task automatic t_late();
        pos = 16'(-500);
        fork
            frame_check(1'h1);
            begin
                // Flag stands, output floating, between the joint edge and the next rise
                repeat (6) @(negedge ref_clk);
                check_val(16'({status_w.late_start, oe_n_w}), 16'h0003, "late flag");
            end
        join
        prev_d = -500;
        frame_check(1'h0);
    endtask

    // Nap with clock low, sleep with clock high, wake on a clock rise
    task automatic t_shutdown();
        adc_host_model_i.pulses(1);
        check_val(16'(status_w), 16'h0000, "strobe ends acquire");
        adc_host_model_i.pulses(1);
        check_val(16'({status_w, status_n, oe_n_w}), 16'h0089, "nap");
        adc_host_model_i.set_clock(1'h1);
        check_val(16'(status_w), 16'h0000, "wake from nap");
        adc_host_model_i.pulses(4);
        check_val(16'({status_w, status_n}), 16'h0022, "sleep");
        adc_host_model_i.set_clock(1'h0);
        adc_host_model_i.set_clock(1'h1);
        check_val(16'({status_w, status_n}), 16'h0000, "wake from sleep");
        adc_host_model_i.set_clock(1'h0);
        // Reference settling time before results are trusted
        repeat (20000) @(negedge ref_clk);
        pos = 16'h0309;
        adc_host_model_i.frame(1'h0);
        prev_d = 777;
        frame_check(1'h0);
    endtask

    task automatic give_verdict();
        $display("Checks %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end

    // Main sequence
    initial
    begin
        ref_clk = 1'h0;
        rst = 1'h1;
        pos = 16'h0000;
        neg = 16'h0000;
        repeat (10) @(negedge ref_clk);
        rst = 1'h0;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_pipeline();
        t_late();
        t_shutdown();
        give_verdict();
    end
endmodule
